// >>> include/plcsr_defines.svh
// Constants of the system status relay bank: bus offsets, bit positions,
// mode codes and timing figures.
// Assumes inclusion by bare name from the package and the status bank module.
`ifndef PLCSR_DEFINES_SVH
`define PLCSR_DEFINES_SVH

// ------------
// Register byte offsets (one aligned word each)
// ------------
`define PLCSR_OFS_WORD0 6'h00
`define PLCSR_OFS_WORD1 6'h04
`define PLCSR_OFS_WORD2 6'h08
`define PLCSR_OFS_WORD3 6'h0C
`define PLCSR_OFS_WORD4 6'h10
`define PLCSR_OFS_CPU_DETAIL 6'h14
`define PLCSR_OFS_IO_DETAIL 6'h18
`define PLCSR_OFS_PROG_DETAIL 6'h1C
`define PLCSR_OFS_ALARM_DETAIL 6'h20
`define PLCSR_OFS_SCAN_CTRL 6'h24

// ------------
// Operating state codes (low four bits of word 0)
// ------------
`define PLCSR_MODE_INIT 4'h0
`define PLCSR_MODE_HALT 4'h1
`define PLCSR_MODE_RUN 4'h2
`define PLCSR_MODE_RUN_F 4'h3
`define PLCSR_MODE_HOLD 4'h4
`define PLCSR_MODE_ERROR 4'h6

// ------------
// Bit positions inside the status words
// ------------
`define PLCSR_B0_CPU 4
`define PLCSR_B0_IO 5
`define PLCSR_B0_PROG 6
`define PLCSR_B0_NVM_WEAR 7
`define PLCSR_B0_FIX_OVR 8
`define PLCSR_B0_CAL 10
`define PLCSR_B0_NET 13
`define PLCSR_B0_RETAIN 15
`define PLCSR_B1_ROM 0
`define PLCSR_B1_RAM 1
`define PLCSR_B1_PMEM 2
`define PLCSR_B1_NVM 3
`define PLCSR_B1_WDT 15
`define PLCSR_B2_IO_MISMATCH 1
`define PLCSR_B3_RUNTIME 0
`define PLCSR_B3_SCAN_OVR 1
`define PLCSR_B4_ZERO 14
`define PLCSR_B4_ONE 15
// Alarm bits of word 0, the only user-clearable ones
`define PLCSR_ALARM_MASK 16'hA580
// Scan control register: period in ms, enable bit
`define PLCSR_SC_EN 16

// ------------
// Timing
// ------------
`define PLCSR_CYC_PER_MS 250000
`define PLCSR_SCAN_LIMIT_MS 200
`define PLCSR_BASE_TICK_MS 50
`define PLCSR_NVM_WEAR_LIMIT 17'h186A0
`define PLCSR_RELAY_HALVES '{1, 2, 4, 8, 10, 20, 40, 80}

`endif

// >>> include/plcsr_pkg.sv
// Types shared by the status relay bank modules.
// Assumes the defines header sits on the include path.
`include "plcsr_defines.svh"

package plcsr_pkg;
    typedef logic [15:0] plcsr_word_t; // One 16-bit status word
    typedef logic [3:0] plcsr_mode_t; // Encoded operating state
    typedef enum logic [0:0] {PLCSR_DP_IDLE, PLCSR_DP_WRITE} plcsr_dphase_t; // Data phase kind
endpackage

// >>> verilog/plcsr_tick_relay.sv
// One timing relay: a square wave counted in base ticks.
// Assumes base_tick is a one-cycle pulse in the hclk domain.
`timescale 1ns/1ns

module plcsr_tick_relay #(
    parameter int HALF_TICKS = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic base_tick,
    input wire logic restart,
    output logic level
);
    logic [7:0] count; // Base ticks within the current half
    logic [7:0] next_count;
    logic next_level;

    // ------------
    // Half-period counter; restart forces the OFF half
    // ------------
    always_comb begin
        next_count = count;
        next_level = level;
        if (restart) begin
            next_count = 8'h00;
            next_level = 1'b0;
        end else if (base_tick) begin
            if (count == 8'(HALF_TICKS - 1)) begin
                next_count = 8'h00;
                next_level = ~level;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 8'h00;
            level <= 1'b0;
        end else begin
            count <= next_count;
            level <= next_level;
        end
    end
endmodule // plcsr_tick_relay

// >>> verilog/plcsr_scan_timer.sv
// Scan duration counter: cycles since the last scan start, saturating.
// Assumes scan_start is a one-cycle pulse from the scan sequencer.
`timescale 1ns/1ns

module plcsr_scan_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic scan_start,
    output logic [31:0] elapsed
);
    logic [31:0] next_elapsed;

    // ------------
    // Count while running; restart at every scan start
    // ------------
    always_comb begin
        next_elapsed = elapsed;
        if (!enable || scan_start) begin
            next_elapsed = 32'h0000_0000;
        end else if (elapsed != 32'hFFFF_FFFF) begin
            next_elapsed = elapsed + 32'h0000_0001; // Saturate, never wrap
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            elapsed <= 32'h0000_0000;
        end else begin
            elapsed <= next_elapsed;
        end
    end
endmodule // plcsr_scan_timer

// >>> verilog/plcsr_status_bank.sv
// System status relay bank with an AHB-Lite register slave.
// Assumes system-side event inputs are synchronous to hclk.
`timescale 1ns/1ns
`include "plcsr_defines.svh"

// Contract
// RULE_01: Low four bits report encoded operating state
// RULE_02: CPU fault flag with detail word
// RULE_03: I/O fault flag with detail word
// RULE_04: Program fault flag with detail word
// RULE_05: Wear alarm after 100000 nonvolatile writes
// RULE_06: Alarm when scan exceeds fixed period
// RULE_07: Alarm on illegal calendar contents
// RULE_08: Alarm on field network transmission error
// RULE_09: Alarm on invalid retained working data
// RULE_10: Only system side writes status bits
// RULE_11: Fatal flags set with error state entry
// RULE_12: Alarm flags set during normal operation
// RULE_13: Separate ROM, RAM, program, nonvolatile faults
// RULE_14: Watchdog and I/O mismatch fatal flags
// RULE_15: Runtime program fault with alarm detail
// RULE_16: Fatal flag when scan exceeds 200 ms
// RULE_17: Eight square-wave relays, OFF at run entry
// RULE_18: Constant zero and constant one bits
// RULE_19: Bit number selects word and position
// RULE_20: Relays refreshed once per scan update
// RULE_21: User may clear alarm flags
// RULE_22: Reserved bits read zero, ignore writes
module plcsr_status_bank
    import plcsr_pkg::*;
#(
    parameter int SCAN_LIMIT_CYCLES = `PLCSR_SCAN_LIMIT_MS * `PLCSR_CYC_PER_MS,
    parameter int BASE_TICK_CYCLES = `PLCSR_BASE_TICK_MS * `PLCSR_CYC_PER_MS,
    parameter int NVM_WEAR_LIMIT = `PLCSR_NVM_WEAR_LIMIT // Writes allowed before alarm
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] op_mode_req,
    input wire logic scan_start,
    input wire logic timer_update,
    input wire logic nvm_write,
    input wire logic cpu_fault_evt,
    input wire logic [15:0] cpu_fault_info,
    input wire logic io_fault_evt,
    input wire logic [15:0] io_fault_info,
    input wire logic program_fault_evt,
    input wire logic [15:0] program_fault_info,
    input wire logic calendar_bad,
    input wire logic net_tx_error,
    input wire logic retained_bad,
    input wire logic system_rom_err,
    input wire logic system_ram_err,
    input wire logic program_memory_err,
    input wire logic nvm_err,
    input wire logic watchdog_expired,
    input wire logic io_mismatch,
    input wire logic runtime_fault,
    input wire logic [15:0] runtime_fault_info
);
    // ------------
    // Declarations
    // ------------
    plcsr_word_t word0, word1, word2, word3, word4; // Status words
    plcsr_word_t next_word0, next_word1, next_word2, next_word3, next_word4;
    plcsr_word_t cpu_fault_detail_word, next_cpu_fault_detail_word;
    plcsr_word_t io_fault_detail_word, next_io_fault_detail_word;
    plcsr_word_t program_fault_detail_word, next_program_fault_detail_word;
    plcsr_word_t alarm_detail_word, next_alarm_detail_word;
    logic [16:0] scan_ctrl, next_scan_ctrl; // Enable and period in ms
    logic [16:0] nvm_writes, next_nvm_writes; // Saturating write count
    logic error_latched, next_error_latched; // Error state held to reset
    logic was_running, next_was_running; // For run-entry detection
    logic [31:0] base_count, next_base_count; // Base tick prescaler
    logic base_tick, next_base_tick;
    plcsr_dphase_t dphase, next_dphase; // Pending data phase kind
    logic [5:0] wr_addr, next_wr_addr; // Latched write offset
    logic [31:0] next_hrdata;
    logic [31:0] scan_elapsed; // Cycles in current scan
    logic [7:0] relay_level; // Free-running relay waves
    logic running; // RUN or RUN-F without error
    logic run_entry; // First cycle of run mode
    logic fatal_now; // Any fatal condition this cycle
    logic fix_overrun; // Completed scan exceeded fixed period
    logic [47:0] fix_limit; // Fixed period in cycles, never wraps
    logic addr_take; // Address phase accepted
    plcsr_word_t alarm_clear; // Write-one-to-clear mask

    localparam int RELAY_HALF [8] = `PLCSR_RELAY_HALVES;

    // ------------
    // Derived conditions
    // ------------
    assign running = !error_latched &&
                     (op_mode_req == `PLCSR_MODE_RUN || op_mode_req == `PLCSR_MODE_RUN_F);
    assign run_entry = running && !was_running;
    assign fix_limit = 48'(scan_ctrl[15:0]) * 48'(`PLCSR_CYC_PER_MS);
    // Judged at scan end so only whole scans are measured
    assign fix_overrun = scan_ctrl[`PLCSR_SC_EN] && scan_start &&
                         48'(scan_elapsed) > fix_limit; // [RULE_06]
    assign fatal_now = cpu_fault_evt | io_fault_evt | program_fault_evt |
                       system_rom_err | system_ram_err | program_memory_err |
                       nvm_err | watchdog_expired | io_mismatch |
                       (running && scan_elapsed > 32'(SCAN_LIMIT_CYCLES));
    assign addr_take = hsel && hready && htrans[1];

    // ------------
    // Relay generators and scan timer
    // ------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_relay
            plcsr_tick_relay #(
                .HALF_TICKS(RELAY_HALF[gi])
            ) u_relay (
                .hclk(hclk),
                .hresetn(hresetn),
                .base_tick(base_tick),
                .restart(run_entry), // [RULE_17]
                .level(relay_level[gi])
            );
        end
    endgenerate

    plcsr_scan_timer u_scan_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(running),
        .scan_start(scan_start),
        .elapsed(scan_elapsed)
    );

    // ------------
    // Base tick prescaler, phase-aligned to run entry
    // ------------
    always_comb begin
        next_base_count = base_count + 32'h0000_0001;
        next_base_tick = 1'b0;
        next_was_running = running;
        if (run_entry) begin
            next_base_count = 32'h0000_0000; // Waves start fresh [RULE_17]
        end else if (base_count == 32'(BASE_TICK_CYCLES - 1)) begin
            next_base_count = 32'h0000_0000;
            next_base_tick = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_count <= 32'h0000_0000;
            base_tick <= 1'b0;
            was_running <= 1'b0;
        end else begin
            base_count <= next_base_count;
            base_tick <= next_base_tick;
            was_running <= next_was_running;
        end
    end

    // ------------
    // AHB-Lite slave: address phase capture and read data
    // ------------
    // Zero wait states; reads are fetched at the address-phase edge
    always_comb begin
        next_dphase = PLCSR_DP_IDLE;
        next_wr_addr = wr_addr;
        next_hrdata = hrdata;
        alarm_clear = 16'h0000;
        if (dphase == PLCSR_DP_WRITE && wr_addr == `PLCSR_OFS_WORD0) begin
            // Only alarm bits take a clear; the rest stay system-owned
            alarm_clear = hwdata[15:0] & `PLCSR_ALARM_MASK; // [RULE_21] [RULE_10]
        end
        if (addr_take) begin
            next_wr_addr = haddr[5:0];
            if (hwrite) begin
                next_dphase = PLCSR_DP_WRITE;
            end else begin
                case (haddr[5:0])
                    `PLCSR_OFS_WORD0: next_hrdata = {16'h0000, word0};
                    `PLCSR_OFS_WORD1: next_hrdata = {16'h0000, word1};
                    `PLCSR_OFS_WORD2: next_hrdata = {16'h0000, word2};
                    `PLCSR_OFS_WORD3: next_hrdata = {16'h0000, word3};
                    `PLCSR_OFS_WORD4: next_hrdata = {16'h0000, word4};
                    `PLCSR_OFS_CPU_DETAIL: next_hrdata = {16'h0000, cpu_fault_detail_word};
                    `PLCSR_OFS_IO_DETAIL: next_hrdata = {16'h0000, io_fault_detail_word};
                    `PLCSR_OFS_PROG_DETAIL: next_hrdata = {16'h0000, program_fault_detail_word};
                    `PLCSR_OFS_ALARM_DETAIL: next_hrdata = {16'h0000, alarm_detail_word};
                    `PLCSR_OFS_SCAN_CTRL: next_hrdata = {15'h0000, scan_ctrl};
                    default: next_hrdata = 32'h0000_0000; // Unmapped reads zero
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase <= PLCSR_DP_IDLE;
            wr_addr <= 6'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dphase <= next_dphase;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1; // Never stretches a data phase
            hresp <= 1'b0; // Always OKAY
        end
    end

    // ------------
    // Status words, detail words and scan control
    // ------------
    always_comb begin
        next_word0 = word0 & ~alarm_clear;
        next_word1 = word1;
        next_word2 = word2;
        next_word3 = word3;
        next_word4 = word4;
        next_cpu_fault_detail_word = cpu_fault_detail_word;
        next_io_fault_detail_word = io_fault_detail_word;
        next_program_fault_detail_word = program_fault_detail_word;
        next_alarm_detail_word = alarm_detail_word;
        next_scan_ctrl = scan_ctrl;
        next_nvm_writes = nvm_writes;
        next_error_latched = error_latched | fatal_now;
        if (dphase == PLCSR_DP_WRITE && wr_addr == `PLCSR_OFS_SCAN_CTRL) begin
            next_scan_ctrl = hwdata[16:0];
        end
        // Wear count saturates just past the limit
        if (nvm_write && nvm_writes <= 17'(NVM_WEAR_LIMIT)) begin
            next_nvm_writes = nvm_writes + 17'h00001;
        end
        // Alarms: set wins over a same-cycle clear [RULE_12]
        if (nvm_write && nvm_writes >= 17'(NVM_WEAR_LIMIT)) begin
            next_word0[`PLCSR_B0_NVM_WEAR] = 1'b1; // [RULE_05]
        end
        if (fix_overrun) begin
            next_word0[`PLCSR_B0_FIX_OVR] = 1'b1; // [RULE_06]
        end
        if (calendar_bad) begin
            next_word0[`PLCSR_B0_CAL] = 1'b1; // [RULE_07]
        end
        if (net_tx_error) begin
            next_word0[`PLCSR_B0_NET] = 1'b1; // [RULE_08]
        end
        if (retained_bad) begin
            next_word0[`PLCSR_B0_RETAIN] = 1'b1; // [RULE_09]
        end
        // Fatal flags land in the same edge as the error code [RULE_11]
        if (cpu_fault_evt) begin
            next_word0[`PLCSR_B0_CPU] = 1'b1; // [RULE_02]
            next_cpu_fault_detail_word = cpu_fault_info; // [RULE_02]
        end
        if (io_fault_evt) begin
            next_word0[`PLCSR_B0_IO] = 1'b1; // [RULE_03]
            next_io_fault_detail_word = io_fault_info; // [RULE_03]
        end
        if (program_fault_evt) begin
            next_word0[`PLCSR_B0_PROG] = 1'b1; // [RULE_04]
            next_program_fault_detail_word = program_fault_info; // [RULE_04]
        end
        next_word1[`PLCSR_B1_ROM] |= system_rom_err; // [RULE_13]
        next_word1[`PLCSR_B1_RAM] |= system_ram_err; // [RULE_13]
        next_word1[`PLCSR_B1_PMEM] |= program_memory_err; // [RULE_13]
        next_word1[`PLCSR_B1_NVM] |= nvm_err; // [RULE_13]
        next_word1[`PLCSR_B1_WDT] |= watchdog_expired; // [RULE_14]
        next_word2[`PLCSR_B2_IO_MISMATCH] |= io_mismatch; // [RULE_14]
        if (running && scan_elapsed > 32'(SCAN_LIMIT_CYCLES)) begin
            next_word3[`PLCSR_B3_SCAN_OVR] = 1'b1; // [RULE_16]
        end
        // Runtime program fault follows its condition level
        next_word3[`PLCSR_B3_RUNTIME] = runtime_fault; // [RULE_15]
        if (runtime_fault) begin
            next_alarm_detail_word = runtime_fault_info; // [RULE_15]
        end
        // Operating state code; error overrides the requested mode
        next_word0[3:0] = next_error_latched ? `PLCSR_MODE_ERROR : op_mode_req; // [RULE_01] [RULE_11]
        // Relays sampled only at the timer update step
        if (run_entry) begin
            next_word4[7:0] = 8'h00; // [RULE_17]
        end else if (timer_update) begin
            next_word4[7:0] = relay_level; // [RULE_20] [RULE_17]
        end
        next_word4[`PLCSR_B4_ZERO] = 1'b0; // [RULE_18]
        next_word4[`PLCSR_B4_ONE] = 1'b1; // [RULE_18]
        // Reserved positions forced to zero [RULE_22] [RULE_19]
        next_word0 = next_word0 & 16'hA5FF;
        next_word1 = next_word1 & 16'h800F;
        next_word2 = next_word2 & 16'h0002;
        next_word3 = next_word3 & 16'h0003;
        next_word4 = next_word4 & 16'hC0FF;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word0 <= 16'h0000;
            word1 <= 16'h0000;
            word2 <= 16'h0000;
            word3 <= 16'h0000;
            word4 <= 16'h8000;
            cpu_fault_detail_word <= 16'h0000;
            io_fault_detail_word <= 16'h0000;
            program_fault_detail_word <= 16'h0000;
            alarm_detail_word <= 16'h0000;
            scan_ctrl <= 17'h00000;
            nvm_writes <= 17'h00000;
            error_latched <= 1'b0;
        end else begin
            word0 <= next_word0;
            word1 <= next_word1;
            word2 <= next_word2;
            word3 <= next_word3;
            word4 <= next_word4;
            cpu_fault_detail_word <= next_cpu_fault_detail_word;
            io_fault_detail_word <= next_io_fault_detail_word;
            program_fault_detail_word <= next_program_fault_detail_word;
            alarm_detail_word <= next_alarm_detail_word;
            scan_ctrl <= next_scan_ctrl;
            nvm_writes <= next_nvm_writes;
            error_latched <= next_error_latched;
        end
    end
endmodule // plcsr_status_bank

// >>> dv/plcsr_bank_asserts.sv
// Concurrent checks on the status bank's bus answer and flag reads.
// Assumes one hclk domain and zero-wait-state reads with registered hrdata.
`timescale 1ns/1ns

module plcsr_bank_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic calendar_bad,
    input wire logic system_rom_err,
    input wire logic watchdog_expired,
    input wire logic runtime_fault
);
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------
    // Read tracking
    // ------------
    logic rd_v; // Data phase of an accepted read is current
    logic [5:0] rd_a; // Offset of that read
    // Captures each read so its data phase can be judged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_v <= 1'b0;
            rd_a <= 6'h00;
        end else begin
            rd_v <= hsel && hready && htrans[1] && !hwrite;
            rd_a <= haddr[5:0];
        end
    end
    // ------------
    // Properties
    // ------------
    // Inputs sampled two edges back are what a read fetched one edge back must show
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not OKAY");
    AST_CONST: assert property (rd_v && rd_a == 6'h10 |-> hrdata[15:14] == 2'h2)
        else $error("constant bits wrong");
    AST_RESV4: assert property (rd_v && rd_a == 6'h10 |-> hrdata[31:16] == 16'h0000
        && hrdata[13:8] == 6'h00) else $error("reserved bits of word 4 set");
    AST_RESV0: assert property (rd_v && rd_a == 6'h00 |-> {hrdata[31:16], hrdata[14],
        hrdata[12:11], hrdata[9]} == 20'h00000) else $error("reserved bits of word 0 set");
    AST_FATAL: assert property (rd_v && rd_a == 6'h00 && $past(watchdog_expired, 2)
        |-> hrdata[3:0] == 4'h6) else $error("fatal cause without error state");
    AST_ROM: assert property (rd_v && rd_a == 6'h04 && $past(system_rom_err, 2)
        |-> hrdata[0]) else $error("rom fault flag missing");
    AST_RUNTIME: assert property (rd_v && rd_a == 6'h0C && $past(runtime_fault, 2)
        |-> hrdata[0]) else $error("runtime fault flag missing");
    AST_CAL: assert property (rd_v && rd_a == 6'h00 && $past(calendar_bad, 2)
        |-> hrdata[10]) else $error("calendar alarm missing");
    COV_RD4: cover property (rd_v && rd_a == 6'h10);
    COV_WR0: cover property (hsel && hready && htrans[1] && hwrite && haddr[5:0] == 6'h00);
    COV_ERR: cover property (rd_v && rd_a == 6'h00 && hrdata[3:0] == 4'h6);
endmodule // plcsr_bank_asserts

// >>> dv/tb_plc_system_status_relays.sv
// Self-checking bench for the status relay bank over AHB-Lite.
// Assumes short scan and tick parameters; the checker is bound below.
`timescale 1ns/1ns

module tb_plc_system_status_relays;
    import plcsr_pkg::*;
    // One row: cause bit, word, flag mask, mode, flags after write, detail offset
    typedef struct {int evb; logic [5:0] wa; plcsr_word_t m; plcsr_mode_t md;
        plcsr_word_t aft; logic [5:0] da;} plcsr_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2; // Whole words only
    logic [3:0] op_mode_req = 4'h2;
    logic scan_start = 1'b0, timer_update = 1'b0, nvm_write = 1'b0;
    logic [12:0] ev = '0; // Cause inputs, one per row
    logic [15:0] info = 16'hC35A, seen1, seen0;
    int err_count = 0, cmp_count = 0;
    plcsr_row_t rows [13] = '{'{0, 6'h00, 16'h0010, 4'h6, 16'h0010, 6'h14},
        '{1, 6'h00, 16'h0020, 4'h6, 16'h0020, 6'h18}, '{2, 6'h00, 16'h0040, 4'h6, 16'h0040, 6'h1C},
        '{3, 6'h00, 16'h0400, 4'h2, 16'h0000, 6'h3C}, '{4, 6'h00, 16'h2000, 4'h2, 16'h0000, 6'h3C},
        '{5, 6'h00, 16'h8000, 4'h2, 16'h0000, 6'h3C}, '{6, 6'h04, 16'h0001, 4'h6, 16'h0001, 6'h3C},
        '{7, 6'h04, 16'h0002, 4'h6, 16'h0002, 6'h3C}, '{8, 6'h04, 16'h0004, 4'h6, 16'h0004, 6'h3C},
        '{9, 6'h04, 16'h0008, 4'h6, 16'h0008, 6'h3C}, '{10, 6'h04, 16'h8000, 4'h6, 16'h8000, 6'h3C},
        '{11, 6'h08, 16'h0002, 4'h6, 16'h0002, 6'h3C}, '{12, 6'h0C, 16'h0001, 4'h2, 16'h0000, 6'h20}};
    // ------------
    // Design under test, short counts
    // ------------
    plcsr_status_bank #(.SCAN_LIMIT_CYCLES(200), .BASE_TICK_CYCLES(4), .NVM_WEAR_LIMIT(4))
        plcsr_status_bank_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .op_mode_req(op_mode_req), .scan_start(scan_start),
        .timer_update(timer_update), .nvm_write(nvm_write), .cpu_fault_evt(ev[0]),
        .cpu_fault_info(info), .io_fault_evt(ev[1]), .io_fault_info(info),
        .program_fault_evt(ev[2]), .program_fault_info(info), .calendar_bad(ev[3]),
        .net_tx_error(ev[4]), .retained_bad(ev[5]), .system_rom_err(ev[6]),
        .system_ram_err(ev[7]), .program_memory_err(ev[8]), .nvm_err(ev[9]),
        .watchdog_expired(ev[10]), .io_mismatch(ev[11]), .runtime_fault(ev[12]),
        .runtime_fault_info(info));
    // Free-running 250 MHz clock
    initial forever #2 hclk = ~hclk;
    // ------------
    // Tasks
    // ------------
    // Single transfer; read data lands in rd at the data-phase edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {26'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwrite <= 1'b0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Reset held four cycles; causes are already low here
    task automatic do_reset();
        @(posedge hclk) hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task automatic pulse_scan();
        @(posedge hclk) scan_start <= 1'b1;
        @(posedge hclk) scan_start <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        give_verdict();
    end
    // ------------
    // Main sequence
    // ------------
    initial begin
        foreach (rows[i]) begin
            do_reset();
            @(posedge hclk) ev[rows[i].evb] <= 1'b1; // Cause held through two reads
            bus(1'b0, rows[i].wa, 0);
            chk("flag", rows[i].m, rd[15:0] & rows[i].m);
            bus(1'b0, 6'h00, 0);
            chk("mode", rows[i].md, rd[3:0]);
            ev <= '0;
            bus(1'b0, rows[i].da, 0);
            chk("detail", rows[i].da == 6'h3C ? 0 : info, rd);
            bus(1'b1, rows[i].wa, rows[i].m);
            bus(1'b0, rows[i].wa, 0);
            chk("after", rows[i].aft, rd[15:0] & rows[i].m);
        end
        for (int k = 0; k < 5; k++) begin // Every plain mode code
            op_mode_req <= 4'(k);
            bus(1'b0, 6'h00, 0);
            chk("mode code", 4'(k), rd[3:0]);
        end
        op_mode_req <= 4'h2;
        do_reset();
        bus(1'b1, 6'h10, 32'hFFFFFFFF);
        bus(1'b1, 6'h3C, 32'hFFFFFFFF);
        bus(1'b0, 6'h10, 0);
        chk("word4", 32'h00008000, rd);
        bus(1'b0, 6'h3C, 0);
        chk("unmapped", 32'h0, rd);
        seen1 = '0;
        seen0 = '0;
        timer_update <= 1'b1;
        repeat (8) begin
            bus(1'b0, 6'h10, 0);
            seen1 |= rd[15:0];
            seen0 |= ~rd[15:0];
        end
        timer_update <= 1'b0;
        chk("relays", 3'h6, {seen1[0], seen0[0], seen1[7]});
        do_reset();
        @(posedge hclk) nvm_write <= 1'b1; // Four writes, at the limit
        repeat (4) @(posedge hclk);
        nvm_write <= 1'b0;
        bus(1'b0, 6'h00, 0);
        chk("wear", 32'h0, rd & 32'h80);
        @(posedge hclk) nvm_write <= 1'b1;
        @(posedge hclk) nvm_write <= 1'b0;
        bus(1'b0, 6'h00, 0);
        chk("wear", 32'h80, rd & 32'h80);
        bus(1'b1, 6'h24, 32'h00010000); // Fixed scan of zero ms always overruns
        pulse_scan();
        repeat (20) @(posedge hclk);
        pulse_scan();
        bus(1'b0, 6'h00, 0);
        chk("fixed overrun", 16'h0102, rd[15:0] & 16'h010F);
        pulse_scan();
        repeat (150) @(posedge hclk);
        bus(1'b0, 6'h0C, 0);
        chk("scan short", 32'h0, rd);
        repeat (60) @(posedge hclk);
        bus(1'b0, 6'h0C, 0);
        chk("scan long", 32'h2, rd);
        bus(1'b0, 6'h00, 0);
        chk("scan error", 4'h6, rd[3:0]);
        give_verdict();
    end
endmodule // tb_plc_system_status_relays

bind plcsr_status_bank plcsr_bank_asserts plcsr_bank_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .calendar_bad(calendar_bad),
    .system_rom_err(system_rom_err), .watchdog_expired(watchdog_expired),
    .runtime_fault(runtime_fault));
